// File: pprp_pkg.sv
/*
 * pprp_pkg: constants, enums and carrier structs for the page permit and
 * ring protection checker. Assumes 16-bit page table entries.
 */
package pprp_pkg;
    // page geometry
    localparam int          PAGE_WORDS       = 1024;
    localparam int          SVC_PARAM_COUNT  = 256;
    // page table entry field positions
    localparam int          WRITE_PERMIT_POS = 15;
    localparam int          READ_PERMIT_POS  = 14;
    localparam int          FETCH_PERMIT_POS = 13;
    localparam int          USED_FLAG_POS    = 12;
    localparam int          WRITTEN_FLAG_POS = 11;
    localparam int          RING_HI_POS      = 10;
    localparam int          RING_LO_POS      = 9;
    // status register field positions
    localparam int          STAT_FETCH_POS   = 15;
    localparam int          STAT_PERMIT_POS  = 14;
    localparam int          STAT_TABLE_HI    = 7;
    localparam int          STAT_TABLE_LO    = 6;
    localparam int          STAT_VPAGE_HI    = 5;
    // interrupt level and codes
    localparam logic [3:0]  IRQ_LEVEL        = 4'he;
    localparam logic [3:0]  PROTECT_CODE     = 4'h2;
    // lowest ring allowed to run privileged instructions
    localparam logic [1:0]  PRIV_RING_MIN    = 2'h2;
    localparam logic [15:0] STATUS_RESET     = 16'h0000;

    typedef enum logic [1:0] {
        ACC_READ,
        ACC_WRITE,
        ACC_FETCH,
        ACC_INDIRECT
    } pprp_access_e;

    typedef enum logic [1:0] {
        INSN_PLAIN,
        INSN_PRIVILEGED,
        INSN_SUPERVISOR
    } pprp_insn_e;

    typedef enum logic {
        STAT_OPEN,
        STAT_LOCKED
    } pprp_lock_e;

    // one translated memory reference
    typedef struct packed {
        pprp_access_e kind;
        logic [15:0]  entry;
        logic [1:0]   table_num;
        logic [5:0]   vpage;
    } pprp_mem_req_s;

    // one instruction about to execute
    typedef struct packed {
        pprp_insn_e   kind;
        logic [7:0]   svc_param;
    } pprp_insn_req_s;
endpackage : pprp_pkg

// File: pprp_check.sv
/*
 * pprp_check: combinational verdict for one reference: page absent,
 * permit failure, ring failure. Assumes the entry is already read out.
 */
`timescale 1ns/1ps
`default_nettype none
module pprp_check (
    input  wire  pprp_pkg::pprp_access_e kind_i,
    input  wire  logic [15:0]            entry_i,
    input  wire  logic [1:0]             cur_ring_i,
    output logic                         page_absent_o,
    output logic                         permit_bad_o,
    output logic                         ring_bad_o
);
    logic       write_permit_bit;
    logic       read_permit_bit;
    logic       fetch_permit_bit;
    logic [1:0] page_ring;

    assign write_permit_bit = entry_i[pprp_pkg::WRITE_PERMIT_POS];
    assign read_permit_bit  = entry_i[pprp_pkg::READ_PERMIT_POS];
    assign fetch_permit_bit = entry_i[pprp_pkg::FETCH_PERMIT_POS];
    assign page_ring = {entry_i[pprp_pkg::RING_HI_POS], entry_i[pprp_pkg::RING_LO_POS]};

    // permit decode; absent page is reported instead of a permit failure
    always_comb begin
        page_absent_o = ~(write_permit_bit | read_permit_bit | fetch_permit_bit);
        case (kind_i)
            pprp_pkg::ACC_WRITE:    permit_bad_o = ~write_permit_bit;
            pprp_pkg::ACC_READ:     permit_bad_o = ~read_permit_bit;
            pprp_pkg::ACC_FETCH:    permit_bad_o = ~fetch_permit_bit;
            pprp_pkg::ACC_INDIRECT: permit_bad_o = ~(fetch_permit_bit | read_permit_bit);
            default:                permit_bad_o = 1'b1;
        endcase
        if (page_absent_o) begin
            permit_bad_o = 1'b0;
        end
    end

    // ring n reaches n and below
    assign ring_bad_o = page_ring > cur_ring_i;
endmodule : pprp_check
`default_nettype wire

// File: pprp_page_permit_ring.sv
/*
 * pprp_page_permit_ring: checks each translated reference against the page
 * permits and rings, blocks privileged instructions in low rings, raises
 * level 14 internal interrupts and captures the paging status.
 * Assumes requests come from same-clock sequencer logic, one per cycle,
 * and that the paging control register ring is presented as cur_ring_i.
 */
`timescale 1ns/1ps
`default_nettype none
module pprp_page_permit_ring #(
    parameter logic [3:0] PAGE_FAULT_CODE = 4'h3,
    parameter logic [3:0] PRIV_INSN_CODE  = 4'h4,
    parameter logic [3:0] SVC_CODE        = 4'h5
) (
    input  wire  logic                     clk_i,
    input  wire  logic                     reset_n_i,
    input  wire  logic                     mem_valid_i,
    input  wire  pprp_pkg::pprp_mem_req_s  mem_req_i,
    input  wire  logic                     insn_valid_i,
    input  wire  pprp_pkg::pprp_insn_req_s insn_req_i,
    input  wire  logic [1:0]               cur_ring_i,
    input  wire  logic                     status_read_i,
    output logic                           done_o,
    output logic                           allow_o,
    output logic                           read_deliver_o,
    output logic                           store_enable_o,
    output logic                           entry_wr_o,
    output logic [15:0]                    entry_data_o,
    output logic                           irq_o,
    output logic [3:0]                     irq_level_o,
    output logic [3:0]                     irq_code_o,
    output logic [7:0]                     svc_param_o,
    output logic [15:0]                    status_o,
    output logic                           status_locked_o
);
    ////////////////////////////////////////////////////////////////////////
    // verdict of the addressed entry
    logic page_absent;
    logic permit_bad;
    logic ring_bad;

    pprp_check u_check (
        .kind_i        (mem_req_i.kind),
        .entry_i       (mem_req_i.entry),
        .cur_ring_i    (cur_ring_i),
        .page_absent_o (page_absent),
        .permit_bad_o  (permit_bad),
        .ring_bad_o    (ring_bad)
    );

    ////////////////////////////////////////////////////////////////////////
    // registered answer state
    logic                 done_ff, nxt_done;
    logic                 allow_ff, nxt_allow;
    logic                 deliver_ff, nxt_deliver;
    logic                 store_ff, nxt_store;
    logic                 entry_wr_ff, nxt_entry_wr;
    logic [15:0]          entry_data_ff, nxt_entry_data;
    logic                 irq_ff, nxt_irq;
    logic [3:0]           code_ff, nxt_code;
    logic [7:0]           svc_ff, nxt_svc;
    logic [15:0]          status_ff, nxt_status;
    pprp_pkg::pprp_lock_e lock_ff, nxt_lock;
    logic [3:0]           level_ff, nxt_level;
    logic                 locked_ff, nxt_locked;

    logic mem_fault;
    logic insn_bad;
    logic is_svc;
    logic mem_ok;

    // classify; a memory reference takes precedence over an instruction check
    always_comb begin
        mem_fault = mem_valid_i & (page_absent | permit_bad | ring_bad);
        // privileged needs ring 2 or 3
        insn_bad  = ~mem_valid_i & insn_valid_i
                  & (insn_req_i.kind == pprp_pkg::INSN_PRIVILEGED)
                  & (cur_ring_i < pprp_pkg::PRIV_RING_MIN);
        is_svc    = ~mem_valid_i & insn_valid_i
                  & (insn_req_i.kind == pprp_pkg::INSN_SUPERVISOR);
        mem_ok    = mem_valid_i & ~mem_fault;
    end

    // next answer; faults suppress every side effect of the access
    always_comb begin
        nxt_done       = mem_valid_i | insn_valid_i;
        nxt_allow      = mem_ok | (~mem_valid_i & insn_valid_i & ~insn_bad);
        nxt_deliver    = mem_ok & (mem_req_i.kind != pprp_pkg::ACC_WRITE);
        nxt_store      = mem_ok & (mem_req_i.kind == pprp_pkg::ACC_WRITE);
        nxt_entry_wr   = mem_ok;
        nxt_entry_data = mem_req_i.entry;
        nxt_entry_data[pprp_pkg::USED_FLAG_POS] = 1'b1;
        if (mem_req_i.kind == pprp_pkg::ACC_WRITE) begin
            nxt_entry_data[pprp_pkg::WRITTEN_FLAG_POS] = 1'b1;
        end
        nxt_irq  = mem_fault | insn_bad | is_svc;
        nxt_level = nxt_irq ? pprp_pkg::IRQ_LEVEL : 4'h0;
        nxt_code = 4'h0;
        if (mem_valid_i & page_absent) begin
            nxt_code = PAGE_FAULT_CODE;
        end else if (mem_valid_i & permit_bad) begin
            nxt_code = pprp_pkg::PROTECT_CODE;
        end else if (mem_valid_i & ring_bad) begin
            nxt_code = PRIV_INSN_CODE;
        end else if (insn_bad) begin
            nxt_code = PRIV_INSN_CODE;
        end else if (is_svc) begin
            nxt_code = SVC_CODE;
        end
        nxt_svc = is_svc ? insn_req_i.svc_param : svc_ff;
    end

    // status capture; a fault in the unlocking cycle wins over the unlock
    always_comb begin
        nxt_status = status_ff;
        nxt_lock   = lock_ff;
        case (lock_ff)
            pprp_pkg::STAT_OPEN: begin
                nxt_lock = pprp_pkg::STAT_OPEN;
            end
            pprp_pkg::STAT_LOCKED: begin
                nxt_lock = status_read_i ? pprp_pkg::STAT_OPEN : pprp_pkg::STAT_LOCKED;
            end
            default: begin
                nxt_lock = pprp_pkg::STAT_OPEN;
            end
        endcase
        if (mem_fault && (lock_ff == pprp_pkg::STAT_OPEN || status_read_i)) begin
            nxt_status = 16'h0000;
            nxt_status[pprp_pkg::STAT_FETCH_POS]  = mem_req_i.kind == pprp_pkg::ACC_FETCH;
            nxt_status[pprp_pkg::STAT_PERMIT_POS] = page_absent | permit_bad;
            nxt_status[pprp_pkg::STAT_TABLE_HI:pprp_pkg::STAT_TABLE_LO] = mem_req_i.table_num;
            nxt_status[pprp_pkg::STAT_VPAGE_HI:0] = mem_req_i.vpage;
            nxt_lock = pprp_pkg::STAT_LOCKED;
        end
        // lock flag kept in its own flop so the pin needs no decode
        nxt_locked = nxt_lock == pprp_pkg::STAT_LOCKED;
    end

    // registers only; every output comes from here
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_ff       <= 1'b0;
            allow_ff      <= 1'b0;
            deliver_ff    <= 1'b0;
            store_ff      <= 1'b0;
            entry_wr_ff   <= 1'b0;
            entry_data_ff <= 16'h0000;
            irq_ff        <= 1'b0;
            code_ff       <= 4'h0;
            svc_ff        <= 8'h00;
            status_ff     <= pprp_pkg::STATUS_RESET;
            lock_ff       <= pprp_pkg::STAT_OPEN;
            level_ff      <= 4'h0;
            locked_ff     <= 1'b0;
        end else begin
            done_ff       <= nxt_done;
            allow_ff      <= nxt_allow;
            deliver_ff    <= nxt_deliver;
            store_ff      <= nxt_store;
            entry_wr_ff   <= nxt_entry_wr;
            entry_data_ff <= nxt_entry_data;
            irq_ff        <= nxt_irq;
            code_ff       <= nxt_code;
            svc_ff        <= nxt_svc;
            status_ff     <= nxt_status;
            lock_ff       <= nxt_lock;
            level_ff      <= nxt_level;
            locked_ff     <= nxt_locked;
        end
    end

    assign done_o          = done_ff;
    assign allow_o         = allow_ff;
    assign read_deliver_o  = deliver_ff;
    assign store_enable_o  = store_ff;
    assign entry_wr_o      = entry_wr_ff;
    assign entry_data_o    = entry_data_ff;
    assign irq_o           = irq_ff;
    // level is fixed, but registered beside irq so it stands only with it
    assign irq_level_o     = level_ff;
    assign irq_code_o      = code_ff;
    assign svc_param_o     = svc_ff;
    assign status_o        = status_ff;
    assign status_locked_o = locked_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks against the request one cycle earlier
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    logic [2:0] req_permits;
    logic [1:0] req_ring;
    assign req_permits = mem_req_i.entry[15:13];
    assign req_ring    = mem_req_i.entry[10:9];

    property p_write_blocked;
        mem_valid_i && mem_req_i.kind == pprp_pkg::ACC_WRITE && !req_permits[2]
            |=> irq_o && !store_enable_o && !entry_wr_o;
    endproperty
    a_write_blocked: assert property (p_write_blocked)
        else $error("store into write protected page not blocked");

    property p_read_blocked;
        mem_valid_i && mem_req_i.kind == pprp_pkg::ACC_READ
            && !req_permits[1] && req_permits != 3'h0
            |=> irq_o && irq_code_o == 4'h2 && !read_deliver_o;
    endproperty
    a_read_blocked: assert property (p_read_blocked)
        else $error("read from read protected page not faulted");

    property p_fetch_blocked;
        mem_valid_i && mem_req_i.kind == pprp_pkg::ACC_FETCH && !req_permits[0]
            |=> !allow_o && irq_o && !read_deliver_o && !entry_wr_o;
    endproperty
    a_fetch_blocked: assert property (p_fetch_blocked)
        else $error("fetch from fetch protected page allowed");

    property p_indirect_ok;
        mem_valid_i && mem_req_i.kind == pprp_pkg::ACC_INDIRECT
            && (req_permits[0] || req_permits[1]) && req_ring <= cur_ring_i
            |=> allow_o && read_deliver_o && !irq_o;
    endproperty
    a_indirect_ok: assert property (p_indirect_ok)
        else $error("indirect read refused despite fetch or read permit");

    property p_absent;
        mem_valid_i && req_permits == 3'h0
            |=> irq_o && irq_code_o == PAGE_FAULT_CODE && irq_level_o == 4'he;
    endproperty
    a_absent: assert property (p_absent)
        else $error("absent page did not give page fault");

    property p_ring;
        mem_valid_i && req_ring > cur_ring_i && !page_absent && !permit_bad
            |=> irq_o && irq_code_o == PRIV_INSN_CODE && !allow_o;
    endproperty
    a_ring: assert property (p_ring)
        else $error("ring violation not trapped as privileged");

    property p_both_report_permit;
        mem_valid_i && permit_bad && ring_bad && !status_locked_o
            |=> status_o[14] && irq_code_o == 4'h2;
    endproperty
    a_both_report_permit: assert property (p_both_report_permit)
        else $error("permit violation lost to ring violation");

    property p_priv;
        !mem_valid_i && insn_valid_i && insn_req_i.kind == pprp_pkg::INSN_PRIVILEGED
            |=> (allow_o == ($past(cur_ring_i) >= 2'h2)) && (irq_o != allow_o);
    endproperty
    a_priv: assert property (p_priv)
        else $error("privileged instruction ring check wrong");

    property p_svc;
        !mem_valid_i && insn_valid_i && insn_req_i.kind == pprp_pkg::INSN_SUPERVISOR
            |=> irq_o && allow_o && irq_code_o == SVC_CODE
                && svc_param_o == $past(insn_req_i.svc_param);
    endproperty
    a_svc: assert property (p_svc)
        else $error("supervisor call did not interrupt");

    property p_lock_hold;
        status_locked_o && !status_read_i |=> $stable(status_o) && status_locked_o;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("locked status changed before read");

    property p_flags;
        mem_ok && mem_req_i.kind == pprp_pkg::ACC_WRITE
            |=> entry_wr_o && entry_data_o[12] && entry_data_o[11] && store_enable_o;
    endproperty
    a_flags: assert property (p_flags)
        else $error("used or written flag not set on store");

    c_fault_then_read: cover property (mem_fault ##1 status_locked_o ##[1:8] status_read_i);
    c_ring_fault:      cover property (mem_valid_i && ring_bad && !permit_bad);
    c_priv_trap:       cover property (insn_bad ##1 irq_o);
endmodule : pprp_page_permit_ring
`default_nettype wire

// File: pprp_seq_model.sv
/*
 * pprp_seq_model: instruction sequencer stand-in that issues references,
 * instructions and status reads to the protection checker.
 * Assumes the bench calls its tasks 1 ns after a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module pprp_seq_model (
    input  wire logic                     clk_i,
    output var  logic                     mem_valid_o,
    output var  pprp_pkg::pprp_mem_req_s  mem_req_o,
    output var  logic                     insn_valid_o,
    output var  pprp_pkg::pprp_insn_req_s insn_req_o,
    output var  logic                     status_read_o
);
    // quiet start, nothing requested before reset lets go
    initial begin
        mem_valid_o   = 1'b0;
        mem_req_o     = '0;
        insn_valid_o  = 1'b0;
        insn_req_o    = '0;
        status_read_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // request held up to the taking edge; answer is settled on return
    // ring and entries set first
    task automatic issue(input logic mv, input pprp_pkg::pprp_mem_req_s mr,
                         input logic iv, input pprp_pkg::pprp_insn_req_s ir,
                         input logic rd);
        mem_valid_o   = mv;
        mem_req_o     = mr;
        insn_valid_o  = iv;
        insn_req_o    = ir;
        status_read_o = rd;
        @(posedge clk_i);
        #1;
    endtask : issue
    // released payload flips so a stale value never passes for a live one
    task automatic idle();
        mem_valid_o   = 1'b0;
        insn_valid_o  = 1'b0;
        status_read_o = 1'b0;
        mem_req_o     = ~mem_req_o;
        insn_req_o    = ~insn_req_o;
        @(posedge clk_i);
        #1;
    endtask : idle
endmodule : pprp_seq_model
`default_nettype wire

// File: pprp_page_permit_ring_test.sv
/*
 * pprp_page_permit_ring_test: self-checking bench for the protection checker.
 * Assumes one-cycle registered answers and the default interrupt codes.
 */
`timescale 1ns/1ps
`default_nettype none
module pprp_page_permit_ring_test;
    localparam logic [3:0] PF_C = 4'h3;
    localparam logic [3:0] PI_C = 4'h4;
    localparam logic [3:0] SV_C = 4'h5;
    logic clk_i = 1'b0, reset_n_i = 1'b0, mv, iv, rd, done, allow, rdel, sten;
    logic ewr, irq, locked;
    logic [1:0] cur_ring = 2'h3;
    logic [3:0] lvl, code;
    logic [7:0] svc;
    logic [15:0] edata, stat;
    pprp_pkg::pprp_mem_req_s mr;
    pprp_pkg::pprp_insn_req_s ir;
    int miscompares = 0, total_checks = 0, cycles = 0;
    logic ok, pv;
    logic [15:0] ent;

    always #2.5 clk_i = ~clk_i;

    pprp_seq_model SEQ (.clk_i(clk_i), .mem_valid_o(mv), .mem_req_o(mr),
        .insn_valid_o(iv), .insn_req_o(ir), .status_read_o(rd));

    pprp_page_permit_ring #(.PAGE_FAULT_CODE(PF_C), .PRIV_INSN_CODE(PI_C),
        .SVC_CODE(SV_C)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .mem_valid_i(mv), .mem_req_i(mr), .insn_valid_i(iv), .insn_req_i(ir),
        .cur_ring_i(cur_ring), .status_read_i(rd), .done_o(done),
        .allow_o(allow), .read_deliver_o(rdel), .store_enable_o(sten),
        .entry_wr_o(ewr), .entry_data_o(edata), .irq_o(irq), .irq_level_o(lvl),
        .irq_code_o(code), .svc_param_o(svc), .status_o(stat),
        .status_locked_o(locked));
    ////////////////////////////////////////////////////////////////////////
    function automatic pprp_pkg::pprp_mem_req_s mreq(input logic [1:0] k,
        input logic [15:0] e, input logic [1:0] t, input logic [5:0] v);
        return '{pprp_pkg::pprp_access_e'(k), e, t, v};
    endfunction : mreq
    // flags are {done, allow, deliver, store, entry write, irq}
    task automatic check_resp(input string nm, input logic [5:0] fl,
                              input logic [3:0] c);
        logic [13:0] e;
        logic [13:0] g;
        e = {fl, (fl[0] ? pprp_pkg::IRQ_LEVEL : 4'h0), c};
        g = {done, allow, rdel, sten, ewr, irq, lvl, (fl[0] ? code : c)};
        total_checks++;
        if (e !== g) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : check_resp
    task automatic check_word(input string nm, input logic [15:0] e,
                              input logic [15:0] g);
        total_checks++;
        if (e !== g) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : check_word
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    // hang guard, far above the roughly 70 cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        check_resp("reset", 6'h00, 4'h0);
        check_word("reset_status", 16'h0000, stat);
        check_word("reset_lock", 16'h0000, {15'h0, locked});
        // permit table: every access kind against every permit pattern
        for (int k = 0; k < 4; k++) begin
            for (int p = 0; p < 8; p++) begin
                ent = {p[2:0], 13'h0000};
                case (k)
                    0: ok = p[1];
                    1: ok = p[2];
                    2: ok = p[0];
                    default: ok = p[0] | p[1];
                endcase
                SEQ.issue(1'b1, mreq(k[1:0], ent, 2'h0, 6'h00), 1'b0, '0, 1'b0);
                check_resp("permit", {1'b1, ok, ok && k != 1, ok && k == 1, ok, !ok},
                           (p == 0) ? PF_C : pprp_pkg::PROTECT_CODE);
                if (ok) check_word("entry_wb", ent | 16'h1000 | ((k == 1) ? 16'h0800 : 16'h0000), edata);
            end
        end
        $display("test permit done");
        // ring table: running ring against page ring, permits all open
        for (int cr = 0; cr < 4; cr++) begin
            for (int pr = 0; pr < 4; pr++) begin
                cur_ring = cr[1:0];
                ok = (pr <= cr);
                SEQ.issue(1'b1, mreq(2'h0, {5'h1c, pr[1:0], 9'h000}, 2'h0, 6'h01),
                          1'b0, '0, 1'b0);
                check_resp("ring", {1'b1, ok, ok, 1'b0, ok, !ok}, PI_C);
            end
        end
        SEQ.idle();
        $display("test ring done");
        // status capture, lock, priority of permit over ring
        SEQ.issue(1'b0, '0, 1'b0, '0, 1'b1);
        check_word("unlock", 16'h0000, {15'h0, locked});
        cur_ring = 2'h0;
        SEQ.issue(1'b1, mreq(2'h2, 16'hc600, 2'h2, 6'h2d), 1'b0, '0, 1'b0);
        check_resp("both_bad", 6'h21, pprp_pkg::PROTECT_CODE);
        check_word("status_fetch", 16'hc0ad, stat);
        SEQ.issue(1'b1, mreq(2'h0, 16'he600, 2'h1, 6'h03), 1'b0, '0, 1'b0);
        check_resp("locked_fault", 6'h21, PI_C);
        check_word("status_held", 16'hc0ad, stat);
        check_word("still_locked", 16'h0001, {15'h0, locked});
        SEQ.issue(1'b0, '0, 1'b0, '0, 1'b1);
        SEQ.issue(1'b1, mreq(2'h0, 16'he600, 2'h1, 6'h03), 1'b0, '0, 1'b0);
        check_word("status_ring", 16'h0043, stat);
        SEQ.idle();
        $display("test status done");
        // instruction kinds in every ring, both extreme call parameters
        for (int cr = 0; cr < 4; cr++) begin
            for (int ik = 0; ik < 3; ik++) begin
                cur_ring = cr[1:0];
                pv = (ik == 1) && (cr < 2);
                SEQ.issue(1'b0, '0, 1'b1, '{pprp_pkg::pprp_insn_e'(ik[1:0]),
                          (cr[0] ? 8'hff : 8'h00)}, 1'b0);
                check_resp("insn", {1'b1, !pv, 3'b000, pv || ik == 2},
                           (ik == 2) ? SV_C : PI_C);
                if (ik == 2) check_word("svc_param", {8'h00, (cr[0] ? 8'hff : 8'h00)}, {8'h00, svc});
            end
        end
        // a reference in the same cycle wins over a privileged instruction
        cur_ring = 2'h0;
        SEQ.issue(1'b1, mreq(2'h0, 16'he000, 2'h0, 6'h00), 1'b1,
                  '{pprp_pkg::INSN_PRIVILEGED, 8'h00}, 1'b0);
        check_resp("ref_wins", 6'h3a, 4'h0);
        SEQ.idle();
        $display("test insn done");
        tally_and_finish();
    end
endmodule : pprp_page_permit_ring_test
`default_nettype wire
